// ===== src/i2s_slave_read.sv
// Two-wire slave port with combined-format reads, auto-increment pointer and bus watchdog.
// Assumes SCL and SDA are open-drain wires resolved outside; link_clk_i oversamples them.
//
// How it works
// - A read is a write phase with address and register pointer, then a repeated start and read.
// - The slave acknowledges its address and the register byte and latches that byte as pointer.
// - After a read address the slave shifts data bytes out on SDA, most significant bit first.
// - A master not-acknowledge stops transmission and releases SDA until the stop.
// - The pointer increments after every byte returned.
// - Each read starts from the address of the latest write, not the advanced pointer.
// - After reset the read start address is zero.
// - A watchdog resets the slave port when the port itself holds the bus.
// - Configuration bit wdt_en enables the watchdog when 1 and disables it when 0.
// - Configuration bit wdt_sel picks a 1 ms period when 0 and 50 ms when 1.
// - The slave answers address 0x68 with the select pin low and 0x69 with it high.
// - A stop straight after a start with no SCL low phase is not recognised.
`timescale 1ns/1ps
module i2s_slave_read #(
  parameter int WDT_SHORT_CYC = i2s_pkg::I2S_WDT_SHORT_CYC,
  parameter int WDT_LONG_CYC = i2s_pkg::I2S_WDT_LONG_CYC
) (
  // Core clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link oversampling clock
  input wire logic link_clk_i,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Strap
  input wire logic address_select_pin_i
);
  import i2s_pkg::*;

  // ****************************************
  // Link domain input synchronisers
  // ****************************************
  logic [3:0] in_m_q;
  logic [3:0] in_s_q;
  logic scl_p_q;
  logic sda_p_q;
  logic link_rst_n;
  logic scl_s;
  logic sda_s;
  logic asel_s;

  always_ff @(posedge link_clk_i) begin
    in_m_q <= {rst_n_i, address_select_pin_i, sda_i, scl_i};
    in_s_q <= in_m_q;
    scl_p_q <= in_s_q[0];
    sda_p_q <= in_s_q[1];
  end

  assign scl_s = in_s_q[0];
  assign sda_s = in_s_q[1];
  assign asel_s = in_s_q[2];
  assign link_rst_n = in_s_q[3];

  i2s_ev_t ev;
  always_comb begin
    ev.scl_rise = scl_s & ~scl_p_q;
    ev.scl_fall = ~scl_s & scl_p_q;
    ev.start = scl_s & scl_p_q & ~sda_s & sda_p_q;
    ev.stop = scl_s & scl_p_q & sda_s & ~sda_p_q;
  end

  // ****************************************
  // Watchdog timeout into link domain
  // ****************************************
  logic wdt_tgl_q;
  logic [2:0] wdt_sync_q;
  logic wdt_hit;

  always_ff @(posedge link_clk_i) begin
    wdt_sync_q <= {wdt_sync_q[1:0], wdt_tgl_q};
  end

  assign wdt_hit = wdt_sync_q[2] ^ wdt_sync_q[1];

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] mem_q [256];
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic mem_we;
  logic [7:0] rd_byte;
  i2s_config_t nv_q;
  i2s_config_t nv_d;

  always_ff @(posedge link_clk_i) begin
    if (mem_we) begin
      mem_q[ptr_q] <= sh_q;
    end
  end

  assign rd_byte = (ptr_q == I2S_CONFIG_OFF) ? nv_q : mem_q[ptr_q];

  // ****************************************
  // Protocol engine
  // ****************************************
  i2s_state_t st_q;
  i2s_state_t st_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  logic rw_q;
  logic rw_d;
  logic [7:0] base_q;
  logic [7:0] base_d;
  logic oe_q;
  logic oe_d;
  logic seen_q;
  logic seen_d;
  logic mack_q;
  logic mack_d;
  logic busy_q;
  logic busy_d;
  logic evt_q;
  logic evt_d;
  logic load_tx;

  assign load_tx = ev.scl_fall & (((st_q == I2S_ACK) & rw_q & (idx_q == 2'h0))
                                | ((st_q == I2S_MACK) & mack_q));

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    idx_d = idx_q;
    rw_d = rw_q;
    ptr_d = ptr_q;
    base_d = base_q;
    oe_d = oe_q;
    nv_d = nv_q;
    seen_d = seen_q | ev.scl_fall;
    mack_d = mack_q;
    mem_we = 1'b0;
    evt_d = evt_q ^ (ev.scl_rise | ev.scl_fall | ev.start | ev.stop);
    if (wdt_hit) begin
      st_d = I2S_IDLE;
      oe_d = 1'b0;
    end else if (ev.start) begin
      st_d = I2S_RX;
      bit_d = 4'h0;
      idx_d = 2'h0;
      seen_d = 1'b0;
      oe_d = 1'b0;
    end else if (ev.stop && seen_q) begin
      st_d = I2S_IDLE;
      oe_d = 1'b0;
    end else if (load_tx) begin
      sh_d = rd_byte;
      ptr_d = ptr_q + 8'h01;
      oe_d = ~rd_byte[7];
      bit_d = 4'h0;
      st_d = I2S_TX;
    end else begin
      unique case (st_q)
        I2S_IDLE: begin
        end
        I2S_RX: begin
          if (ev.scl_rise && bit_q != I2S_BITS_BYTE) begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (ev.scl_fall && bit_q == I2S_BITS_BYTE) begin
            oe_d = 1'b1;
            st_d = I2S_ACK;
            if (idx_q == 2'h0) begin
              if (sh_q[7:1] == {I2S_DEV_ADDR[6:1], asel_s}) begin
                rw_d = sh_q[0];
                if (sh_q[0]) begin
                  ptr_d = base_q;
                end
              end else begin
                oe_d = 1'b0;
                st_d = I2S_IDLE;
              end
            end else if (idx_q == 2'h1) begin
              base_d = sh_q;
              ptr_d = sh_q;
            end else begin
              mem_we = (ptr_q != I2S_CONFIG_OFF);
              if (ptr_q == I2S_CONFIG_OFF) begin
                nv_d = sh_q;
              end
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        I2S_ACK: begin
          if (ev.scl_fall) begin
            oe_d = 1'b0;
            bit_d = 4'h0;
            idx_d = (idx_q == I2S_IDX_DATA) ? I2S_IDX_DATA : idx_q + 2'h1;
            st_d = I2S_RX;
          end
        end
        I2S_TX: begin
          if (ev.scl_fall) begin
            if (bit_q == I2S_BIT_LAST) begin
              oe_d = 1'b0;
              st_d = I2S_MACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              bit_d = bit_q + 4'h1;
              oe_d = ~sh_q[6];
            end
          end
        end
        I2S_MACK: begin
          if (ev.scl_rise) begin
            mack_d = ~sda_s;
          end else if (ev.scl_fall) begin
            st_d = I2S_IDLE;
          end
        end
        default: begin
          st_d = I2S_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
    busy_d = oe_d | (st_d == I2S_TX) | (st_d == I2S_MACK);
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n) begin
      st_q <= I2S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      ptr_q <= I2S_PTR_RST;
      base_q <= I2S_PTR_RST;
      oe_q <= 1'b0;
      nv_q <= I2S_CONFIG_RST;
      seen_q <= 1'b0;
      mack_q <= 1'b0;
      busy_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      idx_q <= idx_d;
      rw_q <= rw_d;
      ptr_q <= ptr_d;
      base_q <= base_d;
      oe_q <= oe_d;
      nv_q <= nv_d;
      seen_q <= seen_d;
      mack_q <= mack_d;
      busy_q <= busy_d;
      evt_q <= evt_d;
    end
  end

  assign sda_oe_o = oe_q;
  assign sda_o = 1'b0;

  // ****************************************
  // Watchdog in core domain
  // ****************************************
  logic [1:0] busy_sync_q;
  logic [2:0] evt_sync_q;
  logic [1:0] en_sync_q;
  logic [1:0] sel_sync_q;
  logic [I2S_WDT_W-1:0] wcnt_q;
  logic [I2S_WDT_W-1:0] wcnt_d;
  logic [I2S_WDT_W-1:0] wlimit;
  logic wdt_tgl_d;

  always_ff @(posedge clk_i) begin
    busy_sync_q <= {busy_sync_q[0], busy_q};
    evt_sync_q <= {evt_sync_q[1:0], evt_q};
    en_sync_q <= {en_sync_q[0], nv_q.wdt_en};
    sel_sync_q <= {sel_sync_q[0], nv_q.wdt_sel};
  end

  assign wlimit = sel_sync_q[1] ? I2S_WDT_W'(WDT_LONG_CYC - 1)
                                : I2S_WDT_W'(WDT_SHORT_CYC - 1);

  always_comb begin
    wcnt_d = wcnt_q + {{(I2S_WDT_W-1){1'b0}}, 1'b1};
    wdt_tgl_d = wdt_tgl_q;
    if (!en_sync_q[1] || !busy_sync_q[1] || (evt_sync_q[2] ^ evt_sync_q[1])) begin
      wcnt_d = '0;
    end else if (wcnt_q >= wlimit) begin
      wcnt_d = '0;
      wdt_tgl_d = ~wdt_tgl_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wcnt_q <= '0;
      wdt_tgl_q <= 1'b0;
    end else begin
      wcnt_q <= wcnt_d;
      wdt_tgl_q <= wdt_tgl_d;
    end
  end

endmodule

// ===== src/i2s_pkg.sv
// Constants, field layouts and carrier types of the two-wire slave read port.
// Assumes a 250 MHz core clock; the link side runs on its own oversampling clock.
package i2s_pkg;

  // ****************************************
  // Register map and reset values
  // ****************************************
  localparam logic [7:0] I2S_CONFIG_OFF = 8'h70;
  localparam logic [7:0] I2S_CONFIG_RST = 8'h00;
  localparam logic [7:0] I2S_PTR_RST = 8'h00;
  localparam logic [6:0] I2S_DEV_ADDR = 7'h68;
  localparam int I2S_WDT_EN_BIT = 1;
  localparam int I2S_WDT_SEL_BIT = 2;

  // ****************************************
  // Protocol counts
  // ****************************************
  localparam logic [3:0] I2S_BITS_BYTE = 4'h8;
  localparam logic [3:0] I2S_BIT_LAST = 4'h7;
  localparam logic [1:0] I2S_IDX_DATA = 2'h2;

  // ****************************************
  // Watchdog timing
  // ****************************************
  localparam int I2S_CLK_HZ = 250000000;
  localparam int I2S_WDT_SHORT_MS = 1;
  localparam int I2S_WDT_LONG_MS = 50;
  localparam int I2S_WDT_SHORT_CYC = I2S_WDT_SHORT_MS * (I2S_CLK_HZ / 1000);
  localparam int I2S_WDT_LONG_CYC = I2S_WDT_LONG_MS * (I2S_CLK_HZ / 1000);
  localparam int I2S_WDT_W = 24;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    I2S_IDLE = 3'h0,
    I2S_RX = 3'h1,
    I2S_ACK = 3'h3,
    I2S_TX = 3'h2,
    I2S_MACK = 3'h6
  } i2s_state_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } i2s_ev_t;

  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic wdt_sel;
    logic wdt_en;
    logic rsvd_lo;
  } i2s_config_t;

endpackage

// ===== tb/i2s_master_model.sv
// Behavioural two-wire bus master: drives SCL and pulls SDA low.
// Assumes the bench resolves SDA as an open-drain wire with a pull-up.
`timescale 1ns/1ps
module i2s_master_model (
  // Bus pins
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // ****
  // Bit sequences
  // ****
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start();
    #20 sda_low_o = 1'b0;
    #60 scl_o = 1'b1;
    #80 sda_low_o = 1'b1;
    #80 scl_o = 1'b0;
  endtask
  task automatic stop();
    #20 sda_low_o = 1'b1;
    #60 scl_o = 1'b1;
    #80 sda_low_o = 1'b0;
    #80;
  endtask
  task automatic bare_start_stop();
    #20 sda_low_o = 1'b0;
    #60 scl_o = 1'b1;
    #80 sda_low_o = 1'b1;
    #80 sda_low_o = 1'b0;
    #80 scl_o = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #20 sda_low_o = !b;
    #60 scl_o = 1'b1;
    #40 r = sda_i;
    #40 scl_o = 1'b0;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!more, r);
  endtask
endmodule

// ===== tb/i2s_slave_read_monitor.sv
// Pin checker for the two-wire slave read port.
// Assumes it is bound onto i2s_slave_read and sees its ports only.
`timescale 1ns/1ps
module i2s_slave_read_monitor (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic address_select_pin_i
);
  // ****
  // Pin relations
  // ****
  chk_rst_quiet: assert property (@(posedge clk_i)
    !rst_n_i [*8] |-> !sda_oe_o) else $error("sda driven in reset");
  chk_rst_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !sda_oe_o [*3]) else $error("sda driven at reset exit");
  chk_open_drain: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    sda_oe_o |-> !sda_o) else $error("sda driven high");
  chk_oe_scl_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $changed(sda_oe_o) |-> !scl_i) else $error("sda moved with scl high");
  chk_oe_settled: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $rose(sda_oe_o) |-> !$past(scl_i) && !$past(scl_i, 2)) else $error("drive too early");
  chk_ack_holds: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $rose(sda_oe_o) |=> sda_oe_o [*2]) else $error("drive too short");
  chk_start_master: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    scl_i && $fell(sda_i) |-> !sda_oe_o) else $error("slave made a start");
  chk_stop_quiet: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    scl_i && $rose(sda_i) |=> !sda_oe_o [*6]) else $error("drive after stop");
  cover property (@(posedge link_clk_i) disable iff (!rst_n_i) $rose(sda_oe_o));
  cover property (@(posedge link_clk_i) disable iff (!rst_n_i) scl_i && $rose(sda_i));
  cover property (@(posedge link_clk_i) disable iff (!rst_n_i) $fell(sda_oe_o) && !scl_i);
endmodule
bind i2s_slave_read i2s_slave_read_monitor mon_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .address_select_pin_i(address_select_pin_i));

// ===== tb/i2s_slave_read_bench.sv
// Self-checking bench for the two-wire slave read port.
// Assumes the master model and the bound pin checker.
`timescale 1ns/1ps
module i2s_slave_read_bench;
  import i2s_pkg::*;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic asel = 1'b0;
  logic scl, mlow, sda_o, sda_oe, ack;
  wire sda = !(mlow || (sda_oe && !sda_o));
  logic [7:0] mem [256];
  logic [7:0] exp_q [$];
  logic [7:0] got;
  logic [7:0] cfg [3] = '{8'h02, 8'h06, 8'h00};
  logic [1:0] oe_e [3] = '{2'b00, 2'b10, 2'b11};
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  event got_ev;
  // ****
  // Clocks, design and master
  // ****
  initial forever #2 clk_i = !clk_i;
  initial begin
    #1.3;
    forever #3 link_clk_i = !link_clk_i;
  end
  i2s_slave_read #(.WDT_SHORT_CYC(200), .WDT_LONG_CYC(500)) dut_u (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .address_select_pin_i(asel));
  i2s_master_model m_u (.scl_o(scl), .sda_low_o(mlow), .sda_i(sda));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic addr(input logic rd);
    m_u.start();
    m_u.wr({I2S_DEV_ADDR[6:1], asel, rd}, ack);
    check({7'h0, ack}, 8'h01);
  endtask
  task automatic wphase(input logic [7:0] r);
    addr(1'b0);
    m_u.wr(r, ack);
    check({7'h0, ack}, 8'h01);
  endtask
  task automatic wbytes(input logic [7:0] base, input int n);
    wphase(base);
    for (int i = 0; i < n; i++) begin
      m_u.wr(mem[8'(base + i)], ack);
      check({7'h0, ack}, 8'h01);
    end
    m_u.stop();
    // Normal-mode idle only; the port has no suspend state
    repeat (500) @(negedge clk_i);
  endtask
  task automatic rbytes(input logic [7:0] base, input int n);
    addr(1'b1);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[8'(base + i)]);
      m_u.rd(i < n - 1, got);
      -> got_ev;
    end
    m_u.stop();
  endtask
  // ****
  // Result watcher and run
  // ****
  initial forever begin
    @(got_ev);
    check(got, exp_q.pop_front());
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(66));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
    end
    do_reset();
    wbytes(8'h00, 4);
    do_reset();
    rbytes(8'h00, 2);
    wphase(8'h01);
    rbytes(8'h01, 3);
    rbytes(8'h01, 2);
    for (int s = 0; s < 2; s++) begin
      @(negedge clk_i);
      asel = s[0];
      repeat (10) @(negedge clk_i);
      for (int a = 0; a < 2; a++) begin
        m_u.start();
        m_u.wr({I2S_DEV_ADDR[6:1], a[0], 1'b0}, ack);
        check({7'h0, ack}, {7'h0, a[0] == s[0]});
        m_u.stop();
      end
      rbytes(8'h01, 1);
    end
    m_u.bare_start_stop();
    m_u.wr({I2S_DEV_ADDR[6:1], asel, 1'b0}, ack);
    check({7'h0, ack}, 8'h01);
    m_u.stop();
    for (int k = 0; k < 3; k++) begin
      do_reset();
      mem[I2S_CONFIG_OFF] = cfg[k];
      wbytes(I2S_CONFIG_OFF, 1);
      wphase(I2S_CONFIG_OFF);
      rbytes(I2S_CONFIG_OFF, 1);
      wphase(I2S_CONFIG_OFF);
      addr(1'b1);
      repeat (300) @(negedge clk_i);
      check({7'h0, sda_oe}, {7'h0, oe_e[k][1]});
      repeat (400) @(negedge clk_i);
      check({7'h0, sda_oe}, {7'h0, oe_e[k][0]});
    end
    wrap_up();
  end
endmodule
